// ### hdl/ptpc_rx_capture.sv
// per-port peer-delay capture registers and ingress drop counters
//
// How it works
// - with auto-refresh set, a peer-delay request overwrites nanoseconds, seconds and both correction words.
// - with auto-refresh clear, reception leaves the capture fields alone and software maintains them.
// - nanoseconds sit in bits 29:0, bit 30 reads zero, and the field resets to zero.
// - correction bits 63:32 fill the whole correction-high register, read-write, reset zero.
// - correction bits 31:16 sit in bits 31:16 of correction-low, the low half reads zero.
// - the sub-nanosecond fraction of the correction is dropped and never stored.
// - a 32-bit per-port counter counts packets dropped for a bad UDP checksum.
// - a 32-bit per-port counter counts packets removed by ingress message filtering.
// - each dropped or filtered packet is flagged to the receiving MAC as errored.
// - both counters stop at all ones and never wrap.
// - writing zero clears a counter, losing what it held.
// - port registers live in a shared space chosen by bank select and a two-bit port select.
// - a message is filtered when the mask bit indexed by its message type is set.
//
// hazards and trade-offs
// a capture and a software write to the capture words on the same edge: the capture wins,
// because a half-written time would be worse than a lost software value; the auto bit write
// itself is still taken so software can always turn auto-refresh off.
// a drop and a software write to a tally on the same edge: the write wins, so a clear is
// never undone by a packet that happened to arrive at the same moment.
// a packet with a bad checksum that is also filtered counts only as a checksum drop, so the
// two tallies never count one packet twice; the mac still sees it once as errored.
// the tallies hold at all ones instead of wrapping, so a stuck high count means saturation,
// never a small count after a wrap.
// port select 3 has no registers behind it: writes vanish and reads return zero.
//
`timescale 1ns/1ps
`include "ptpc_defines.svh"
module ptpc_rx_capture
  import ptpc_pkg::*;
(
  input  wire logic        CLOCK,            // 50 MHz system clock
  input  wire logic        RESET,            // synchronous, active high
  input  wire logic        REG_WR,           // register write strobe
  input  wire logic        REG_RD,           // register read strobe
  input  wire logic [8:0]  REG_ADDR,         // register byte offset
  input  wire logic [31:0] REG_WDATA,        // write data
  input  wire logic [2:0]  BANK_SEL,         // bank selector
  input  wire logic [1:0]  PORT_SEL,         // port selector
  input  wire logic [15:0] MSG_FILTER_MASK,  // message_type_filter_mask
  input  wire logic        RX_PKT_VALID,     // one-cycle: parsed ptp packet at ingress
  input  wire logic [1:0]  RX_PORT,          // ingress port of the event
  input  wire logic [3:0]  RX_MSG_TYPE,      // message type of the packet
  input  wire logic        RX_IS_PDREQ,      // packet is a peer-delay request
  input  wire logic        RX_BAD_CHKSUM,    // packet has bad udp checksum
  input  wire logic [29:0] RX_CAPTURED_NANOSECONDS,         // captured_nanoseconds at ingress
  input  wire logic [3:0]  RX_CAPTURED_SECONDS,        // captured_seconds at ingress
  input  wire logic [63:0] RX_CORRECTION,    // correction_value, full 64 bits
  output logic [31:0]      REG_RDATA,        // registered read data
  output logic             REG_RVALID,       // one-cycle read answer
  output logic             RX_MAC_ERROR,     // one-cycle: report packet as errored
  output logic [1:0]       RX_MAC_ERR_PORT   // port of that errored packet
);

  localparam int NP = `PTPC_NPORTS;

  logic [NP-1:0]              auto_reg;
  logic [`PTPC_NS_MSB:0]      ns_reg     [NP];
  logic [`PTPC_SEC_MSB:0]     sec_reg    [NP];
  ptpc_word_t                 cf_hi_reg  [NP];
  logic [15:0]                cf_lo_reg  [NP];
  ptpc_word_t                 chk_cnt    [NP];
  ptpc_word_t                 flt_cnt    [NP];
  logic [NP-1:0]              capture_hit;
  logic [NP-1:0]              port_wr;
  logic                       bank_hit;
  logic                       drop_chk;
  logic                       drop_flt;

  // port-selected register access only within the port bank
  assign bank_hit = (BANK_SEL == `PTPC_PORT_BANK) && (PORT_SEL < 2'(NP));
  // bad checksum takes precedence so a packet is counted once
  assign drop_chk = RX_PKT_VALID && RX_BAD_CHKSUM;
  assign drop_flt = RX_PKT_VALID && !RX_BAD_CHKSUM && MSG_FILTER_MASK[RX_MSG_TYPE];

  // per-port strobes; decoding once keeps the register processes short
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      capture_hit[p] = auto_reg[p] && RX_PKT_VALID && RX_IS_PDREQ && (RX_PORT == 2'(p));
      port_wr[p]     = REG_WR && bank_hit && (PORT_SEL == 2'(p));
    end
  end

  // capture registers: hardware capture and software write per port
  always_ff @(posedge CLOCK) begin
    for (int p = 0; p < NP; p++) begin
      if (RESET) begin
        auto_reg[p]  <= 1'b0;
        ns_reg[p]    <= '0;
        sec_reg[p]   <= '0;
        cf_hi_reg[p] <= `PTPC_ZERO32;
        cf_lo_reg[p] <= '0;
      end else if (capture_hit[p]) begin
        // all four fields load on the same edge; hardware beats a racing write
        ns_reg[p]    <= RX_CAPTURED_NANOSECONDS;
        sec_reg[p]   <= RX_CAPTURED_SECONDS;
        cf_hi_reg[p] <= RX_CORRECTION[63:32];
        cf_lo_reg[p] <= RX_CORRECTION[31:16];
        if (port_wr[p] && REG_ADDR == `PTPC_OFF_PDREQ_NS)
          auto_reg[p] <= REG_WDATA[`PTPC_AUTO_BIT];
      end else if (port_wr[p]) begin
        // with auto clear only software touches the fields
        case (REG_ADDR)
          `PTPC_OFF_PDREQ_NS: begin
            auto_reg[p] <= REG_WDATA[`PTPC_AUTO_BIT];
            ns_reg[p]   <= REG_WDATA[`PTPC_NS_MSB:0];
          end
          `PTPC_OFF_PDREQ_SEC:   sec_reg[p]   <= REG_WDATA[`PTPC_SEC_MSB:0];
          `PTPC_OFF_PDREQ_CF_HI: cf_hi_reg[p] <= REG_WDATA;
          `PTPC_OFF_PDREQ_CF_LO: cf_lo_reg[p] <= REG_WDATA[31:`PTPC_CF_LO_LSB];
          default: ;
        endcase
      end
    end
  end

  // drop tallies: one saturating counter per port and per kind of drop
  for (genvar p = 0; p < NP; p++) begin : g_tally

    // packets dropped for a bad udp checksum
    ptpc_sat_tally chk_u (
      .clock     (CLOCK),
      .reset     (RESET),
      .wr_en     (port_wr[p] && (REG_ADDR == `PTPC_OFF_CHKSUM_DROP)),
      .wr_data   (REG_WDATA),
      .event_hit (drop_chk && (RX_PORT == 2'(p))),
      .count     (chk_cnt[p])
    );

    // packets removed by the message type filter
    ptpc_sat_tally flt_u (
      .clock     (CLOCK),
      .reset     (RESET),
      .wr_en     (port_wr[p] && (REG_ADDR == `PTPC_OFF_FILTER_DROP)),
      .wr_data   (REG_WDATA),
      .event_hit (drop_flt && (RX_PORT == 2'(p))),
      .count     (flt_cnt[p])
    );

  end

  // errored-packet report toward the receiving mac
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      RX_MAC_ERROR    <= 1'b0;
      RX_MAC_ERR_PORT <= 2'h0;
    end else begin
      RX_MAC_ERROR    <= drop_chk || drop_flt;
      RX_MAC_ERR_PORT <= RX_PORT;
    end
  end

  // read path; unmapped offsets and other banks read zero
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      REG_RDATA  <= `PTPC_ZERO32;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      REG_RDATA  <= `PTPC_ZERO32;
      if (REG_RD && bank_hit) begin
        case (REG_ADDR)
          `PTPC_OFF_PDREQ_NS:    REG_RDATA <= {auto_reg[PORT_SEL], 1'b0, ns_reg[PORT_SEL]};
          `PTPC_OFF_PDREQ_SEC:   REG_RDATA <= {28'h0000000, sec_reg[PORT_SEL]};
          `PTPC_OFF_PDREQ_CF_HI: REG_RDATA <= cf_hi_reg[PORT_SEL];
          `PTPC_OFF_PDREQ_CF_LO: REG_RDATA <= {cf_lo_reg[PORT_SEL], 16'h0000};
          `PTPC_OFF_CHKSUM_DROP: REG_RDATA <= chk_cnt[PORT_SEL];
          `PTPC_OFF_FILTER_DROP: REG_RDATA <= flt_cnt[PORT_SEL];
          default:               REG_RDATA <= `PTPC_ZERO32;
        endcase
      end
    end
  end

endmodule

// saturating 32-bit drop tally; a software write beats a drop on the same edge
module ptpc_sat_tally
  import ptpc_pkg::*;
(
  input  wire logic       clock,      // system clock
  input  wire logic       reset,      // synchronous, active high
  input  wire logic       wr_en,      // software write to this tally
  input  wire ptpc_word_t wr_data,    // value written, zero clears
  input  wire logic       event_hit,  // one packet dropped on this edge
  output ptpc_word_t      count       // current tally
);

  ptpc_word_t count_reg;
  ptpc_word_t count_next;

  // write first, then a saturating step; holding at all ones keeps the value honest
  always_comb begin
    count_next = count_reg;
    if (wr_en)
      count_next = wr_data;
    else if (event_hit && (count_reg != `PTPC_MAX32))
      count_next = count_reg + 32'h00000001;
  end

  // tally flip-flop
  always_ff @(posedge clock) begin
    if (reset)
      count_reg <= `PTPC_ZERO32;
    else
      count_reg <= count_next;
  end

  assign count = count_reg;

endmodule

// ### shared/ptpc_defines.svh
// register offsets, field positions, reset values and sizes for the peer-delay capture bank
`ifndef PTPC_DEFINES_SVH
`define PTPC_DEFINES_SVH
`define PTPC_OFF_PDREQ_NS      9'h17c
`define PTPC_OFF_PDREQ_SEC     9'h178
`define PTPC_OFF_PDREQ_CF_HI   9'h180
`define PTPC_OFF_PDREQ_CF_LO   9'h184
`define PTPC_OFF_CHKSUM_DROP   9'h188
`define PTPC_OFF_FILTER_DROP   9'h18c
`define PTPC_PORT_BANK         3'h1
`define PTPC_AUTO_BIT          31
`define PTPC_NS_MSB            29
`define PTPC_SEC_MSB           3
`define PTPC_CF_LO_LSB         16
`define PTPC_ZERO32            32'h00000000
`define PTPC_MAX32             32'hffffffff
`define PTPC_NPORTS            3
`endif

// ### shared/ptpc_pkg.sv
// types shared by the peer-delay capture bank
package ptpc_pkg;
  typedef logic [1:0]  ptpc_port_t;
  typedef logic [31:0] ptpc_word_t;
endpackage

// ### verif/ptpc_chk.sv
// port-level assertions for the peer-delay capture bank
`timescale 1ns/1ps
module ptpc_chk (
  input wire logic        CLOCK, RESET, REG_RD, REG_RVALID, // clock, reset, read handshake
  input wire logic        RX_PKT_VALID, RX_BAD_CHKSUM, RX_MAC_ERROR, // ingress event, error report
  input wire logic [8:0]  REG_ADDR,        // offset
  input wire logic [2:0]  BANK_SEL,        // bank
  input wire logic [31:0] REG_RDATA,       // read data
  input wire logic [15:0] MSG_FILTER_MASK, // filter mask
  input wire logic [3:0]  RX_MSG_TYPE,     // message type
  input wire logic [1:0]  RX_PORT, RX_MAC_ERR_PORT // ports
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // a drop is a bad checksum or a masked message type
  property p_err; RX_PKT_VALID && (RX_BAD_CHKSUM || MSG_FILTER_MASK[RX_MSG_TYPE]) |=> RX_MAC_ERROR && RX_MAC_ERR_PORT == $past(RX_PORT); endproperty
  a_err: assert property (p_err) else $error("drop not reported");
  property p_noerr; !(RX_PKT_VALID && (RX_BAD_CHKSUM || MSG_FILTER_MASK[RX_MSG_TYPE])) |=> !RX_MAC_ERROR; endproperty
  a_noerr: assert property (p_noerr) else $error("spurious error report");
  property p_rd; REG_RD |=> REG_RVALID; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_norv; !REG_RD |=> !REG_RVALID; endproperty
  a_norv: assert property (p_norv) else $error("unasked read answer");
  // idle data returns to zero so a stale word is never taken for an answer
  property p_idle; !REG_RVALID |-> REG_RDATA == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_bank; REG_RD && BANK_SEL != 3'h1 |=> REG_RDATA == 32'h0; endproperty
  a_bank: assert property (p_bank) else $error("other bank answered");
  property p_bit30; REG_RD && REG_ADDR == 9'h17c |=> !REG_RDATA[30]; endproperty
  a_bit30: assert property (p_bit30) else $error("reserved bit set");
  property p_lo; REG_RD && REG_ADDR == 9'h184 |=> REG_RDATA[15:0] == 16'h0; endproperty
  a_lo: assert property (p_lo) else $error("low correction half set");
endmodule
bind ptpc_rx_capture ptpc_chk chk_u (.CLOCK, .RESET, .REG_RD, .REG_RVALID, .RX_PKT_VALID, .RX_BAD_CHKSUM,
  .RX_MAC_ERROR, .REG_ADDR, .BANK_SEL, .REG_RDATA, .MSG_FILTER_MASK, .RX_MSG_TYPE, .RX_PORT, .RX_MAC_ERR_PORT);

// ### verif/ptpc_rx_capture_tb.sv
// self-checking bench for the peer-delay capture bank
`timescale 1ns/1ps
module ptpc_rx_capture_tb;
  import ptpc_pkg::*;
  logic        CLOCK = 1'b0, RESET = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, RX_PKT_VALID = 1'b0;
  logic        RX_IS_PDREQ = 1'b0, RX_BAD_CHKSUM = 1'b0, REG_RVALID, RX_MAC_ERROR;
  logic [8:0]  REG_ADDR = 9'h0;
  logic [2:0]  BANK_SEL = 3'h1;
  logic [1:0]  PORT_SEL = 2'h0, RX_PORT = 2'h0, RX_MAC_ERR_PORT;
  logic [3:0]  RX_MSG_TYPE = 4'h0, RX_CAPTURED_SECONDS = 4'h0;
  logic [15:0] MSG_FILTER_MASK = 16'h0;
  logic [29:0] RX_CAPTURED_NANOSECONDS = 30'h0;
  logic [63:0] RX_CORRECTION = 64'h0;
  ptpc_word_t  REG_WDATA = 32'h0, REG_RDATA;
  ptpc_word_t  mdl [3][6]; // expected words, offsets 0x178 upward
  int          errors = 0, total_checks = 0, cycles = 0;
  ptpc_rx_capture dut_u (.*);
  initial forever #10 CLOCK = ~CLOCK;
  // watchdog well above the few hundred cycles the run needs
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      final_report();
    end
  end
  task automatic chk(input ptpc_word_t got, input ptpc_word_t exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // writable bits per word: seconds, auto+ns, high, low half, two counters
  function automatic ptpc_word_t msk(input int i);
    return i == 0 ? 32'hf : i == 1 ? 32'hbfffffff : i == 3 ? 32'hffff0000 : 32'hffffffff;
  endfunction
  // one access; an idle edge first keeps strobes from being assigned twice in a step
  task automatic acc(input logic w, input logic [1:0] p, input logic [8:0] a, input ptpc_word_t d);
    @(posedge CLOCK);
    #1;
    {REG_WR, REG_RD, PORT_SEL, REG_ADDR, REG_WDATA} = {w, !w, p, a, d};
    @(posedge CLOCK);
    #1;
    {REG_WR, REG_RD} = 2'b00;
    chk({31'h0, REG_RVALID}, {31'h0, !w});
    if (!w) chk(REG_RDATA, d);
  endtask
  // a zero write and a bad-checksum drop on the same edge: the write wins
  task automatic wpk(input logic [1:0] p);
    @(posedge CLOCK);
    #1;
    {REG_WR, PORT_SEL, REG_ADDR, REG_WDATA} = {1'b1, p, 9'h188, 32'h0};
    {RX_PKT_VALID, RX_PORT, RX_IS_PDREQ, RX_BAD_CHKSUM} = {1'b1, p, 1'b0, 1'b1};
    @(posedge CLOCK);
    #1;
    {REG_WR, RX_PKT_VALID} = 2'b00;
    mdl[p][4] = 32'h0;
    chk({31'h0, RX_MAC_ERROR}, 32'h1);
  endtask
  task automatic wm(input logic [1:0] p, input int i, input ptpc_word_t d);
    acc(1'b1, p, 9'h178 + 9'(4 * i), d);
    mdl[p][i] = d & msk(i);
  endtask
  task automatic rall();
    for (int p = 0; p < 3; p++) for (int i = 0; i < 6; i++) acc(1'b0, 2'(p), 9'h178 + 9'(4 * i), mdl[p][i]);
  endtask
  task automatic pkt(input logic [1:0] p, input logic pd, input logic bad, input logic [3:0] t);
    logic drop;
    drop = bad | MSG_FILTER_MASK[t];
    @(posedge CLOCK);
    #1;
    {RX_PKT_VALID, RX_PORT, RX_IS_PDREQ, RX_BAD_CHKSUM, RX_MSG_TYPE} = {1'b1, p, pd, bad, t};
    {RX_CAPTURED_NANOSECONDS, RX_CAPTURED_SECONDS, RX_CORRECTION} = {30'($urandom), 4'($urandom), $urandom, $urandom};
    if (bad && mdl[p][4] != 32'hffffffff) mdl[p][4] += 1;
    if (!bad && drop && mdl[p][5] != 32'hffffffff) mdl[p][5] += 1;
    if (pd && mdl[p][1][31]) mdl[p][0:3] = '{{28'h0, RX_CAPTURED_SECONDS}, {2'b10, RX_CAPTURED_NANOSECONDS}, RX_CORRECTION[63:32],
      {RX_CORRECTION[31:16], 16'h0}};
    @(posedge CLOCK);
    #1;
    RX_PKT_VALID = 1'b0;
    chk({31'h0, RX_MAC_ERROR}, {31'h0, drop});
    if (drop) chk({30'h0, RX_MAC_ERR_PORT}, {30'h0, p});
  endtask
  initial begin
    logic pd;
    void'($urandom(31387));
    foreach (mdl[p, i]) mdl[p][i] = 32'h0;
    repeat (5) @(posedge CLOCK);
    #1;
    RESET = 1'b0;
    rall();
    BANK_SEL = 3'h2;
    acc(1'b1, 2'h0, 9'h188, 32'h5a);
    acc(1'b0, 2'h0, 9'h188, 32'h0);
    BANK_SEL = 3'h1;
    acc(1'b1, 2'h3, 9'h188, 32'h5a);
    acc(1'b0, 2'h3, 9'h188, 32'h0);
    pkt(2'h0, 1'b1, 1'b0, 4'h2);
    // auto on for ports 0 and 1 only, set once before the random traffic
    for (int p = 0; p < 2; p++) wm(2'(p), 1, {1'b1, 31'($urandom)});
    for (int i = 0; i < 4; i++) wm(2'h2, i, $urandom & 32'h7fffffff);
    MSG_FILTER_MASK = (16'($urandom) & 16'hfffb) | 16'h0020;
    for (int n = 0; n < 60; n++) begin
      pd = 1'($urandom);
      pkt(2'($urandom_range(0, 2)), pd, !pd && 1'($urandom), pd ? 4'h2 : 4'($urandom));
    end
    rall();
    wm(2'h1, 4, 32'hfffffffe);
    wm(2'h2, 5, 32'hffffffff);
    repeat (2) pkt(2'h1, 1'b0, 1'b1, 4'h5);
    pkt(2'h2, 1'b0, 1'b0, 4'h5);
    wm(2'h0, 4, 32'h0);
    wpk(2'h1);
    rall();
    final_report();
  end
endmodule
